/* pts_pkg.sv */
// Constants and types shared by the system time and snapshot block
// How it works
// RQ1 - Transmit snapshot holds the time sampled within two clocks of the delimiter.
// RQ2 - Receive snapshot lags delimiter by at most three PHY plus two clocks.
// RQ3 - Snapshots fewer than four clocks apart skip the second frame.
// RQ4 - Delimiter events from either direction cross domains before the time is captured.
// RQ5 - A 64-bit system time counter feeds every snapshot.
// RQ6 - Initialisation loads the counter with the update value.
// RQ7 - Correction adds or subtracts the update offset in one step.
// RQ8 - Accumulator adds the addend each clock; its carry ticks the counter.
// RQ9 - Accumulator and addend are both 32 bits wide.
// RQ10 - Ticks nominally come at 50 MHz, advancing 20 ns each.
// RQ11 - Software derives drift and rewrites the addend while running.
// RQ12 - The reference clock is the system bus clock.
// RQ13 - Header: type octet 0, version octet 1, sequence 30, interval 33.
// RQ14 - Header position depends on raw Ethernet, IPv4 or IPv6 transport.
// RQ15 - Time splits into a seconds word and a nanoseconds word.
// RQ16 - Rollover select picks the nanosecond wrap point; each wrap bumps seconds.
// RQ17 - No valid receive snapshot reports an all-ones time.
// RQ18 - Accumulator wraps modulo two to the 32 and keeps its remainder.
// RQ19 - Coarse updates act next clock and beat a fine tick.
package pts_pkg;
    localparam logic [31:0] NS_DIG_MAX   = 32'h3B9A_C9FF;
    localparam logic [31:0] NS_BIN_MAX   = 32'h7FFF_FFFF;
    localparam logic [31:0] TICK_NS      = 32'h0000_0014;
    localparam int          SNAP_GAP_CYC = 3;
    localparam logic [15:0] ETYPE_PTP    = 16'h88F7;
    localparam logic [15:0] ETYPE_IPV4   = 16'h0800;
    localparam logic [15:0] ETYPE_IPV6   = 16'h86DD;
    localparam logic [6:0]  OCT_ETYPE_HI = 7'h0C;
    localparam logic [6:0]  OCT_ETYPE_LO = 7'h0D;
    localparam logic [6:0]  HDR_ETH      = 7'h0E;
    localparam logic [6:0]  HDR_IPV4     = 7'h2A;
    localparam logic [6:0]  HDR_IPV6     = 7'h4A;
    localparam logic [6:0]  OFS_TYPE     = 7'h00;
    localparam logic [6:0]  OFS_VER      = 7'h01;
    localparam logic [6:0]  OFS_SEQ      = 7'h1E;
    localparam logic [6:0]  OFS_LOGI     = 7'h21;
    localparam logic [3:0]  MAX_EVENT    = 4'h3;
    localparam logic [3:0]  PTP_V1       = 4'h1;
    localparam logic [3:0]  PTP_V2       = 4'h2;

    typedef enum logic [3:0] {
        XP_NONE = 4'b0001,
        XP_ETH  = 4'b0010,
        XP_IPV4 = 4'b0100,
        XP_IPV6 = 4'b1000
    } pts_xport_t;
endpackage

/* pts_snap.sv */
// One snapshot channel: delimiter crossing, gap guard and time capture
`timescale 1ns/1ps
module pts_snap
    import pts_pkg::*;
#(
    parameter int GAP = SNAP_GAP_CYC
) (
    input  wire logic        clk,        // Reference clock
    input  wire logic        rst,        // Synchronous reset
    input  wire logic        ce,         // Clock enable
    input  wire logic        sfd_tgl,    // Delimiter toggle from PHY domain
    input  wire logic        armed,      // Snapshot wanted for this frame
    input  wire logic [63:0] time_in,    // Live system time
    output logic      [63:0] stamp_q,    // Captured time
    output logic             hit_q,      // Capture pulse
    output logic             skip_q      // Skipped-snapshot pulse
);
    localparam int GW = 4;
    localparam logic [GW-1:0] GAP_C = GW'(GAP);

    // Gap counter width limits the guard; refuse it at elaboration
    if (GAP < 1 || GAP > 15) begin : g_gap_chk
        $error("GAP out of range");
    end

    logic          s1_q, s2_q, s3_q;
    logic [GW-1:0] gap_q;
    wire           evt_w    = s2_q ^ s3_q;
    wire           gap_ok_w = (gap_q >= GAP_C);
    wire           take_w   = evt_w && armed && gap_ok_w;

    // Two-stage synchroniser and edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce) begin
            s1_q <= sfd_tgl;   // see RQ4
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Gap counter restarts on every capture and saturates
    always_ff @(posedge clk) begin
        if (rst) begin
            gap_q <= GAP_C;
        end else if (ce) begin
            if (take_w) begin
                gap_q <= '0;             // see RQ3
            end else if (!gap_ok_w) begin
                gap_q <= gap_q + 1'b1;
            end
        end
    end

    // Capture and pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            stamp_q <= '0;
            hit_q   <= 1'b0;
            skip_q  <= 1'b0;
        end else if (ce) begin
            hit_q  <= take_w;
            skip_q <= evt_w && armed && !gap_ok_w;   // see RQ3
            if (take_w) begin
                stamp_q <= time_in;                  // see RQ1
            end
        end
    end

    property p_capture;
        @(posedge clk) disable iff (rst)
        (ce && take_w) |=> (hit_q && stamp_q == $past(time_in));
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed"); // see RQ1

    property p_gap;
        @(posedge clk) disable iff (rst)
        (ce && hit_q) ##1 ce |-> !hit_q;
    endproperty
    a_gap: assert property (p_gap) else $error("snapshots too close"); // see RQ3

    property p_skip;
        @(posedge clk) disable iff (rst)
        (ce && evt_w && armed && !gap_ok_w) |=> (skip_q && !hit_q && $stable(stamp_q));
    endproperty
    a_skip: assert property (p_skip) else $error("skip with capture"); // see RQ3

    c_hit: cover property (@(posedge clk) disable iff (rst) hit_q);
endmodule

/* pts_top.sv */
// System time counter, fine and coarse correction, snapshots and header parse
`timescale 1ns/1ps
module pts_top
    import pts_pkg::*;
#(
    parameter int GAP = SNAP_GAP_CYC
) (
    input  wire logic        clk,                        // Reference clock (bus clock), see RQ12
    input  wire logic        rst,                        // Synchronous reset
    input  wire logic        ce,                         // Clock enable
    input  wire logic        tx_sfd_tgl,                 // Transmit delimiter toggle
    input  wire logic        rx_sfd_tgl,                 // Receive delimiter toggle
    input  wire logic        tx_stamp_req,               // Current tx frame wants a stamp
    input  wire logic        fine_update_en,             // Fine correction on
    input  wire logic        nanosecond_rollover_select, // 1 digital, 0 binary
    input  wire logic [31:0] addend,                     // Fine correction addend
    input  wire logic [31:0] upd_sec,                    // Update seconds
    input  wire logic [31:0] upd_ns,                     // Update nanoseconds
    input  wire logic        init_req,                   // Load time pulse
    input  wire logic        corr_req,                   // Step time pulse
    input  wire logic        corr_sub,                   // Step subtracts
    input  wire logic        rx_sof,                     // Receive frame start
    input  wire logic        rx_byte_vld,                // Receive byte valid
    input  wire logic [7:0]  rx_byte,                    // Receive byte
    output logic      [31:0] sys_sec_q,                  // Seconds word
    output logic      [31:0] sys_ns_q,                   // Nanoseconds word
    output logic      [63:0] tx_stamp_q,                 // Transmit stamp
    output logic             tx_stamp_vld_q,             // Transmit stamp pulse
    output logic             tx_skip_q,                  // Transmit stamp skipped
    output logic             rx_skip_q,                  // Receive stamp skipped
    output logic      [63:0] rx_stamp_q,                 // Receive stamp or all ones
    output logic             rx_done_q,                  // Receive header decided
    output logic             rx_ptp_q,                   // Frame was a PTP event
    output logic      [3:0]  rx_type_q,                  // Message type
    output logic      [15:0] rx_seq_q,                   // Sequence identifier
    output logic      [7:0]  rx_log_q                    // Log message interval
);
    // Rollover point and per-tick step
    wire [31:0] ns_max_w  = nanosecond_rollover_select ? NS_DIG_MAX : NS_BIN_MAX; // see RQ16
    wire [31:0] ns_lim_w  = ns_max_w + 32'h0000_0001;
    wire [32:0] ns_step_w = {1'b0, sys_ns_q} + {1'b0, TICK_NS};                   // see RQ10
    wire        wrap_w    = ns_step_w > {1'b0, ns_max_w};
    wire [31:0] ns_inc_w  = wrap_w ? (ns_step_w[31:0] - ns_lim_w) : ns_step_w[31:0];
    wire [31:0] sec_inc_w = sys_sec_q + {31'h0000_0000, wrap_w};                 // see RQ16

    // Coarse step arithmetic
    wire [32:0] ns_add_w  = {1'b0, sys_ns_q} + {1'b0, upd_ns};
    wire        add_wr_w  = ns_add_w > {1'b0, ns_max_w};
    wire [31:0] ns_addr_w = add_wr_w ? (ns_add_w[31:0] - ns_lim_w) : ns_add_w[31:0];
    wire [31:0] sec_add_w = sys_sec_q + upd_sec + {31'h0000_0000, add_wr_w};
    wire [32:0] ns_sub_w  = {1'b0, sys_ns_q} - {1'b0, upd_ns};
    wire        borrow_w  = ns_sub_w[32];
    wire [31:0] ns_subr_w = borrow_w ? (ns_sub_w[31:0] + ns_lim_w) : ns_sub_w[31:0];
    wire [31:0] sec_sub_w = sys_sec_q - upd_sec - {31'h0000_0000, borrow_w};
    wire [31:0] ns_cor_w  = corr_sub ? ns_subr_w : ns_addr_w;                    // see RQ7
    wire [31:0] sec_cor_w = corr_sub ? sec_sub_w : sec_add_w;

    // Fine accumulator, carry is the tick
    logic [31:0] acc_q;
    wire  [32:0] acc_sum_w = {1'b0, acc_q} + {1'b0, addend};                    // see RQ9
    wire         tick_w    = fine_update_en ? acc_sum_w[32] : 1'b1;              // see RQ8

    // Accumulator keeps its remainder
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= '0;
        end else if (ce && fine_update_en) begin
            acc_q <= acc_sum_w[31:0];   // see RQ18
        end
    end

    // System time: load beats step beats tick
    always_ff @(posedge clk) begin
        if (rst) begin
            sys_sec_q <= '0;
            sys_ns_q  <= '0;
        end else if (ce) begin
            if (init_req) begin
                sys_sec_q <= upd_sec;          // see RQ6
                sys_ns_q  <= upd_ns;           // see RQ19
            end else if (corr_req) begin
                sys_sec_q <= sec_cor_w;        // see RQ7
                sys_ns_q  <= ns_cor_w;
            end else if (tick_w) begin
                sys_sec_q <= sec_inc_w;        // see RQ5
                sys_ns_q  <= ns_inc_w;         // see RQ15
            end
        end
    end

    // Snapshot channels, 0 transmit and 1 receive
    wire        [1:0]  tgl_w   = {rx_sfd_tgl, tx_sfd_tgl};
    wire        [1:0]  arm_w   = {1'b1, tx_stamp_req};
    wire        [63:0] time_w  = {sys_sec_q, sys_ns_q};                          // see RQ5
    logic       [63:0] stamp_w [2];
    logic       [1:0]  hit_w;
    logic       [1:0]  skip_w;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            pts_snap #(.GAP(GAP)) u_snap (
                .clk     (clk),
                .rst     (rst),
                .ce      (ce),
                .sfd_tgl (tgl_w[gi]),     // see RQ4
                .armed   (arm_w[gi]),
                .time_in (time_w),
                .stamp_q (stamp_w[gi]),
                .hit_q   (hit_w[gi]),     // see RQ2
                .skip_q  (skip_w[gi])
            );
        end
    endgenerate

    // Transmit results and receive skip pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_stamp_q     <= '0;
            tx_stamp_vld_q <= 1'b0;
            tx_skip_q      <= 1'b0;
            rx_skip_q      <= 1'b0;
        end else if (ce) begin
            tx_stamp_q     <= stamp_w[0];
            tx_stamp_vld_q <= hit_w[0];
            tx_skip_q      <= skip_w[0];
            rx_skip_q      <= skip_w[1];
        end
    end

    // Receive header parse
    pts_xport_t  xp_q;
    logic [6:0]  idx_q;
    logic [7:0]  ety_hi_q;
    logic [3:0]  ver_q;
    logic        have_q;
    logic [6:0]  base_w;
    always_comb begin
        case (xp_q)
            XP_ETH:  base_w = HDR_ETH;     // see RQ14
            XP_IPV4: base_w = HDR_IPV4;
            XP_IPV6: base_w = HDR_IPV6;
            default: base_w = 7'h7F;
        endcase
    end
    wire [15:0] ety_w   = {ety_hi_q, rx_byte};
    wire        at_w    = rx_byte_vld && (xp_q != XP_NONE);
    wire        dec_w   = at_w && (idx_q == base_w + OFS_LOGI);                  // see RQ13
    wire        ver_ok  = (ver_q == PTP_V1) || (ver_q == PTP_V2);
    wire        ptp_ok  = ver_ok && (rx_type_q <= MAX_EVENT);
    wire        good_w  = ptp_ok && have_q;

    // Octet index and transport selection
    always_ff @(posedge clk) begin
        if (rst || (ce && rx_sof)) begin
            idx_q    <= '0;
            xp_q     <= XP_NONE;
            ety_hi_q <= '0;
        end else if (ce && rx_byte_vld) begin
            if (idx_q != 7'h7F) begin
                idx_q <= idx_q + 7'h01;
            end
            if (idx_q == OCT_ETYPE_HI) begin
                ety_hi_q <= rx_byte;
            end
            if (idx_q == OCT_ETYPE_LO) begin
                if (ety_w == ETYPE_PTP) begin
                    xp_q <= XP_ETH;
                end else if (ety_w == ETYPE_IPV4) begin
                    xp_q <= XP_IPV4;
                end else if (ety_w == ETYPE_IPV6) begin
                    xp_q <= XP_IPV6;
                end
            end
        end
    end

    // Header fields; snapshot presence set wins over frame start
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_type_q <= '0;
            ver_q     <= '0;
            rx_seq_q  <= '0;
            rx_log_q  <= '0;
            have_q    <= 1'b0;
        end else if (ce) begin
            if (hit_w[1]) begin
                have_q <= 1'b1;
            end else if (rx_sof) begin
                have_q <= 1'b0;
            end
            if (at_w && idx_q == base_w + OFS_TYPE) begin
                rx_type_q <= rx_byte[3:0];                   // see RQ13
            end
            if (at_w && idx_q == base_w + OFS_VER) begin
                ver_q <= rx_byte[3:0];
            end
            if (at_w && idx_q == base_w + OFS_SEQ) begin
                rx_seq_q[15:8] <= rx_byte;
            end
            if (at_w && idx_q == base_w + OFS_SEQ + 7'h01) begin
                rx_seq_q[7:0] <= rx_byte;
            end
            if (dec_w) begin
                rx_log_q <= rx_byte;
            end
        end
    end

    // Receive decision
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_done_q  <= 1'b0;
            rx_ptp_q   <= 1'b0;
            rx_stamp_q <= '1;
        end else if (ce) begin
            rx_done_q <= dec_w;
            if (dec_w) begin
                rx_ptp_q   <= ptp_ok;
                rx_stamp_q <= good_w ? stamp_w[1] : '1;      // see RQ17
            end
        end
    end

    property p_init;
        @(posedge clk) disable iff (rst)
        (ce && init_req) |=> (sys_sec_q == $past(upd_sec) && sys_ns_q == $past(upd_ns));
    endproperty
    a_init: assert property (p_init) else $error("load not applied"); // see RQ6

    property p_corr;
        @(posedge clk) disable iff (rst)
        (ce && corr_req && !init_req) |=> (sys_ns_q == $past(ns_cor_w));
    endproperty
    a_corr: assert property (p_corr) else $error("step not applied"); // see RQ19

    property p_tick;
        @(posedge clk) disable iff (rst)
        (ce && tick_w && !wrap_w && !init_req && !corr_req)
            |=> (sys_ns_q == $past(sys_ns_q) + TICK_NS && sys_sec_q == $past(sys_sec_q));
    endproperty
    a_tick: assert property (p_tick) else $error("tick step wrong"); // see RQ8

    property p_hold;
        @(posedge clk) disable iff (rst)
        (ce && !tick_w && !init_req && !corr_req) |=> $stable(sys_ns_q);
    endproperty
    a_hold: assert property (p_hold) else $error("time moved without tick"); // see RQ8

    property p_wrap;
        @(posedge clk) disable iff (rst)
        (ce && tick_w && wrap_w && !init_req && !corr_req)
            |=> (sys_sec_q == $past(sys_sec_q) + 32'h0000_0001);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap missed seconds"); // see RQ16

    property p_acc;
        @(posedge clk) disable iff (rst)
        (ce && fine_update_en) |=> (acc_q == $past(acc_q) + $past(addend));
    endproperty
    a_acc: assert property (p_acc) else $error("accumulator wrong"); // see RQ18

    property p_ones;
        @(posedge clk) disable iff (rst)
        (ce && dec_w && !good_w) |=> (rx_stamp_q == '1 && rx_done_q);
    endproperty
    a_ones: assert property (p_ones) else $error("missing all-ones stamp"); // see RQ17

    property p_rx_good;
        @(posedge clk) disable iff (rst)
        (ce && dec_w && good_w) |=> (rx_stamp_q == $past(stamp_w[1]));
    endproperty
    a_rx_good: assert property (p_rx_good) else $error("rx stamp wrong"); // see RQ2

    c_init: cover property (@(posedge clk) disable iff (rst) ce && init_req);
    c_wrap: cover property (@(posedge clk) disable iff (rst) ce && tick_w && wrap_w);
    c_rx:   cover property (@(posedge clk) disable iff (rst) rx_done_q && rx_ptp_q);
endmodule

/* pts_mac_model.sv */
// Behavioural MAC transmit and receive paths facing the snapshot block
`timescale 1ns/1ps
module pts_mac_model
    import pts_pkg::*;
(
    input  wire logic       clk,         // Reference clock
    output logic            tx_sfd_tgl,  // Transmit delimiter toggle
    output logic            rx_sfd_tgl,  // Receive delimiter toggle
    output logic            rx_sof,      // Frame start pulse
    output logic            rx_byte_vld, // Byte valid pulse
    output logic      [7:0] rx_byte      // Frame byte
);
    // Quiet lines at time zero
    initial begin
        tx_sfd_tgl  = 1'b0;
        rx_sfd_tgl  = 1'b0;
        rx_sof      = 1'b0;
        rx_byte_vld = 1'b0;
        rx_byte     = 8'h00;
    end

    // Delimiter leaves a few ns after the edge, as from an unrelated PHY clock
    task automatic send_tx();
        @(posedge clk);
        #3 tx_sfd_tgl = ~tx_sfd_tgl;
    endtask

    // Frame start, sfd delimiters one cycle apart, then the bytes up to the log octet
    task automatic send_rx(input logic [15:0] et, input logic [7:0] b0, b1,
                           input logic [15:0] seq, input logic [7:0] lg,
                           input int sfd, input bit slow);
        int         base;
        logic [7:0] b;
        base = (et == ETYPE_IPV4) ? 42 : (et == ETYPE_IPV6) ? 74 : 14;
        @(posedge clk);
        rx_sof <= 1'b1;
        @(posedge clk);
        rx_sof <= 1'b0;
        for (int i = 0; i < sfd; i++) begin
            if (i > 0) @(posedge clk);
            #3 rx_sfd_tgl = ~rx_sfd_tgl;
        end
        for (int i = 0; i <= base + 33; i++) begin
            b = 8'(i) ^ 8'h5A;
            if (i == 12) b = et[15:8];
            if (i == 13) b = et[7:0];
            if (i == base) b = b0;
            if (i == base + 1) b = b1;
            if (i == base + 30) b = seq[15:8];
            if (i == base + 31) b = seq[7:0];
            if (i == base + 33) b = lg;
            @(posedge clk);
            rx_byte_vld <= 1'b1;
            rx_byte     <= b;
            // Slow sender leaves a gap with a changed byte value
            if (slow) begin
                @(posedge clk);
                rx_byte_vld <= 1'b0;
                rx_byte     <= ~b;
            end
        end
        @(posedge clk);
        rx_byte_vld <= 1'b0;
        rx_byte     <= ~b;
    endtask
endmodule

/* pts_top_tb_top.sv */
// Self-checking bench for the system time and snapshot block
`timescale 1ns/1ps
module pts_top_tb_top
    import pts_pkg::*;
;
    typedef struct {
        logic [2:0]  kind;
        logic [63:0] v;
        logic [28:0] info;
    } pts_exp_t;

    logic        clk, rst, ce, tx_stamp_req, fine_update_en, nanosecond_rollover_select;
    logic        init_req, corr_req, corr_sub, tx_sfd_tgl, rx_sfd_tgl, rx_sof, rx_byte_vld;
    logic        tx_stamp_vld_q, tx_skip_q, rx_skip_q, rx_done_q, rx_ptp_q, ptp;
    logic [3:0]  rx_type_q;
    logic [7:0]  rx_byte, rx_log_q;
    logic [15:0] rx_seq_q;
    logic [15:0] rnd = 16'hD9B5;
    logic [31:0] addend, upd_sec, upd_ns, sys_sec_q, sys_ns_q, wrap;
    logic [63:0] tx_stamp_q, rx_stamp_q;
    int          failures = 0;
    int          checks = 0;
    pts_exp_t    q [$];
    logic [15:0] f_et [7] = '{ETYPE_PTP, ETYPE_IPV4, ETYPE_IPV6, ETYPE_PTP, ETYPE_IPV4,
                              ETYPE_IPV6, ETYPE_PTP};
    logic [7:0]  f_b0 [7] = '{8'hF0, 8'h01, 8'h03, 8'h08, 8'h00, 8'h02, 8'h01};
    logic [7:0]  f_b1 [7] = '{8'h02, 8'h01, 8'h02, 8'h02, 8'h03, 8'h12, 8'h01};
    int          f_sfd [7] = '{1, 1, 1, 1, 1, 0, 2};

    pts_top #(.GAP(SNAP_GAP_CYC)) dut (
        .clk, .rst, .ce, .tx_sfd_tgl, .rx_sfd_tgl, .tx_stamp_req, .fine_update_en,
        .nanosecond_rollover_select, .addend, .upd_sec, .upd_ns, .init_req, .corr_req,
        .corr_sub, .rx_sof, .rx_byte_vld, .rx_byte, .sys_sec_q, .sys_ns_q, .tx_stamp_q,
        .tx_stamp_vld_q, .tx_skip_q, .rx_skip_q, .rx_stamp_q, .rx_done_q, .rx_ptp_q,
        .rx_type_q, .rx_seq_q, .rx_log_q
    );
    pts_mac_model mac (
        .clk, .tx_sfd_tgl, .rx_sfd_tgl, .rx_sof, .rx_byte_vld, .rx_byte
    );

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic check(input logic [63:0] seen, exp, input string what);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Op bit 0 loads, bit 1 steps; both at once probes priority
    task automatic load(input logic [31:0] s, n, input logic [1:0] op, input logic sub);
        @(posedge clk);
        upd_sec  <= s;
        upd_ns   <= n;
        init_req <= op[0];
        corr_req <= op[1];
        corr_sub <= sub;
        @(posedge clk);
        init_req <= 1'b0;
        corr_req <= 1'b0;
    endtask

    task automatic time_is(input logic [31:0] s, n);
        @(negedge clk);
        check({sys_sec_q, sys_ns_q}, {s, n}, "time");
    endtask

    // Oldest note against each result pulse as it appears
    task automatic take(input logic [2:0] k, input logic [63:0] v, input logic [28:0] inf);
        pts_exp_t e;
        if (q.size() == 0) begin
            failures++;
            $display("[FAIL] %0t unexpected result kind %0d", $time, k);
            return;
        end
        e = q.pop_front();
        check(64'(k), 64'(e.kind), "result kind");
        check(v, e.v, "stamp");
        check(64'(inf), 64'(e.info), "header fields");
    endtask

    always @(negedge clk) begin
        if (tx_stamp_vld_q === 1'b1) take(3'h0, tx_stamp_q, 29'h0);
        if (tx_skip_q === 1'b1) take(3'h1, 64'h0, 29'h0);
        if (rx_done_q === 1'b1) take(3'h2, rx_stamp_q, {rx_ptp_q, rx_type_q, rx_seq_q, rx_log_q});
        if (rx_skip_q === 1'b1) take(3'h3, 64'h0, 29'h0);
    end

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        tx_stamp_req = 1'b1;
        fine_update_en = 1'b0;
        nanosecond_rollover_select = 1'b1;
        addend = 32'h0000_0000;
        upd_sec = 32'h0000_0000;
        upd_ns = 32'h0000_0000;
        init_req = 1'b0;
        corr_req = 1'b0;
        corr_sub = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({sys_sec_q, sys_ns_q}, 64'h0, "reset time");
        check(rx_stamp_q, '1, "reset rx stamp");
        // Wrap in both rollover modes, tick every clock, load beats step
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            nanosecond_rollover_select <= m[0];
            wrap = m[0] ? NS_DIG_MAX : NS_BIN_MAX;
            rnd = lfsr_next(rnd);
            load({16'h0000, rnd}, wrap - 9, 2'h3, 1'b0);
            time_is({16'h0000, rnd}, wrap - 9);
            time_is({16'h0000, rnd} + 1, 32'h0000_000A);
        end
        // Enable low freezes the time after one last tick
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        time_is({16'h0000, rnd} + 1, 32'h0000_001E);
        // Frozen time: steps with carry and borrow
        @(posedge clk);
        ce <= 1'b1;
        fine_update_en <= 1'b1;
        addend <= 32'h0000_0000;
        load(32'h0000_0007, 32'h0000_0064, 2'h1, 1'b0);
        time_is(32'h0000_0007, 32'h0000_0064);
        load(32'h0000_0002, NS_DIG_MAX, 2'h2, 1'b0);
        time_is(32'h0000_000A, 32'h0000_0063);
        load(32'h0000_0001, 32'h0000_0064, 2'h2, 1'b1);
        time_is(32'h0000_0008, NS_DIG_MAX);
        // Addend rewritten while running; carries over whole periods give two ticks
        for (int a = 0; a < 2; a++) begin
            @(posedge clk);
            addend <= a[0] ? 32'h4000_0000 : 32'h8000_0000;
            load(32'h0000_0000, 32'h0000_0000, 2'h1, 1'b0);
            repeat (a[0] ? 8 : 4) @(posedge clk);
            time_is(32'h0000_0000, 32'h0000_0028);
        end
        // Transmit: stamp, close second delimiter skipped, unarmed ignored
        @(posedge clk);
        fine_update_en <= 1'b0;
        load(32'h0000_000A, 32'h0000_03E8, 2'h1, 1'b0);
        q.push_back('{3'h0, {32'h0000_000A, 32'h0000_0424}, 29'h0});
        q.push_back('{3'h1, 64'h0, 29'h0});
        mac.send_tx();
        mac.send_tx();
        repeat (7) @(posedge clk);
        tx_stamp_req <= 1'b0;
        mac.send_tx();
        repeat (6) @(posedge clk);
        tx_stamp_req <= 1'b1;
        repeat (2) @(posedge clk);
        q.push_back('{3'h0, {32'h0000_000A, 32'h0000_058C}, 29'h0});
        mac.send_tx();
        repeat (4) @(posedge clk);
        // Receive frames over each transport, frozen time
        @(posedge clk);
        fine_update_en <= 1'b1;
        addend <= 32'h0000_0000;
        load(32'h0000_0014, 32'h0000_01F4, 2'h1, 1'b0);
        for (int f = 0; f < 7; f++) begin
            rnd = lfsr_next(rnd);
            ptp = (f_b1[f][3:0] inside {PTP_V1, PTP_V2}) && (f_b0[f][3:0] <= MAX_EVENT);
            if (f_sfd[f] > 1) q.push_back('{3'h3, 64'h0, 29'h0});
            q.push_back('{3'h2, (ptp && f_sfd[f] > 0) ? {32'h0000_0014, 32'h0000_01F4} : '1,
                          {ptp, f_b0[f][3:0], rnd, rnd[7:0] ^ 8'hC3}});
            mac.send_rx(f_et[f], f_b0[f], f_b1[f], rnd, rnd[7:0] ^ 8'hC3, f_sfd[f], f[0]);
            repeat (4) @(posedge clk);
        end
        for (int k = 0; k < 200 && q.size() > 0; k++) @(negedge clk);
        if (q.size() > 0) begin
            failures++;
            $display("[FAIL] %0t results still pending", $time);
        end
        tally_and_finish();
    end
endmodule
